//--- tsm_pkg.sv
package tsm_pkg;

  // Wishbone register map (byte addresses)
  localparam int unsigned TSM_WB_AW      = 8;
  localparam logic [7:0]  TSM_ADDR_CTRL  = 8'h00;
  localparam logic [7:0]  TSM_ADDR_SMC   = 8'h08;

  // Reset values and writable bits
  localparam logic [15:0] TSM_SMC_RESET  = 16'h0000;
  localparam logic [15:0] TSM_SMC_WMASK  = 16'hfff7;
  localparam logic        TSM_RUN_RESET  = 1'h0;

  // Counter control register fields
  localparam int unsigned TSM_CTRL_RUN_BIT  = 0;
  localparam int unsigned TSM_CTRL_TRIG_BIT = 1;
  localparam int unsigned TSM_CTRL_FILTERED_EXTERNAL_TRIGGER_BIT = 2;

  // Slave mode codes
  localparam logic [2:0]  TSM_SM_OFF     = 3'h0;
  localparam logic [2:0]  TSM_SM_RESET   = 3'h4;
  localparam logic [2:0]  TSM_SM_GATED   = 3'h5;
  localparam logic [2:0]  TSM_SM_TRIGGER = 3'h6;
  localparam logic [2:0]  TSM_SM_EXTCLK  = 3'h7;

  // Trigger source codes
  localparam logic [2:0]  TSM_TS_CH1_EDGE = 3'h4;
  localparam logic [2:0]  TSM_TS_CH1      = 3'h5;
  localparam logic [2:0]  TSM_TS_CH2      = 3'h6;
  localparam logic [2:0]  TSM_TS_FILTERED_EXTERNAL_TRIGGER     = 3'h7;

  // Prescaler codes
  localparam logic [1:0]  TSM_PS_DIV1 = 2'h0;
  localparam logic [1:0]  TSM_PS_DIV2 = 2'h1;
  localparam logic [1:0]  TSM_PS_DIV4 = 2'h2;

  // Sampling base clock equals the kernel clock (200 MHz)
  localparam int unsigned TSM_CLK_MHZ = 200;
  localparam int unsigned TSM_DTS_MHZ = 200;
  localparam logic [4:0]  TSM_DTS_DIV = 5'(TSM_CLK_MHZ / TSM_DTS_MHZ);

  // Slave mode control register layout, bit 15 down to bit 0
  typedef struct packed {
    logic       polarity;
    logic       clock_mode2;
    logic [1:0] prescale;
    logic [3:0] filter;
    logic       sync;
    logic [2:0] source;
    logic       reserved;
    logic [2:0] mode;
  } tsm_smc_type;

  // Control handed to the counter core
  typedef struct packed {
    logic run_enable;
    logic count_tick;
    logic reinit;
    logic trig_level;
    logic trig_rise;
  } tsm_ctl_type;

  // Consecutive equal samples needed per filter code
  function automatic logic [3:0] tsm_filter_len(input logic [3:0] code);
    logic [3:0] n;
    n = 4'h8;
    unique case (code)
      4'h0: n = 4'h1;
      4'h1: n = 4'h2;
      4'h2: n = 4'h4;
      4'h4, 4'h6, 4'h8, 4'hb, 4'he: n = 4'h6;
      4'ha, 4'hd: n = 4'h5;
      default: n = 4'h8;
    endcase
    return n;
  endfunction

  // Sampling divider mask in base clock ticks per filter code
  function automatic logic [4:0] tsm_filter_mask(input logic [3:0] code);
    logic [4:0] m;
    m = 5'h00;
    if (code >= 4'hd) begin
      m = 5'h1f;
    end else if (code >= 4'ha) begin
      m = 5'h0f;
    end else if (code >= 4'h8) begin
      m = 5'h07;
    end else if (code >= 4'h6) begin
      m = 5'h03;
    end else if (code >= 4'h4) begin
      m = 5'h01;
    end
    return m;
  endfunction

endpackage

//--- tsm_filter.sv
`timescale 1ns/1ps
module tsm_filter
  import tsm_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sample_en_i,
  input  wire logic       level_i,
  input  wire logic [3:0] len_i,
  output logic            level_o
);

  logic [3:0] run_cnt;

  // Output moves only after len_i consecutive samples differ from it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_cnt <= 4'h0;
      level_o <= 1'h0;
    end else if (sample_en_i) begin
      if (level_i == level_o) begin
        run_cnt <= 4'h0;
      end else if (run_cnt + 4'h1 >= len_i) begin
        run_cnt <= 4'h0;
        level_o <= level_i;
      end else begin
        run_cnt <= run_cnt + 4'h1;
      end
    end
  end

endmodule

//--- tsm_slave_mode.sv
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module tsm_slave_mode
  import tsm_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [TSM_WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 external_trigger_pin_i,
  input  wire logic [3:0]           internal_trigger_i,
  input  wire logic                 channel1_filtered_raw_i,
  input  wire logic                 filtered_channel1_input_i,
  input  wire logic                 filtered_channel2_input_i,
  output tsm_ctl_type               ctl_o
);

  tsm_smc_type smc;
  logic        run_enable;
  logic        ext_sync1;
  logic        ext_sync2;
  logic        pol_q;
  logic [2:0]  ps_cnt;
  logic [4:0]  dts_cnt;
  logic [4:0]  samp_cnt;
  logic        dts_tick;
  logic        samp_en;
  logic        filtered_external_trigger;
  logic        filtered_external_trigger_q;
  logic        ch1_q;
  logic        trig_delay;
  logic        trig_q;
  logic        wb_req;

  logic        ext_pol;
  logic        prescaled_external_trigger;
  logic        channel1_edge_pulse;
  logic        trigger_input_signal;
  logic        trig_eff;
  logic        trig_rise;
  logic        filtered_external_trigger_rise;
  logic        next_tick;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Wishbone: one wait state, write and read data at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == TSM_ADDR_SMC) begin
          wb_dat_o <= {16'h0000, smc & TSM_SMC_WMASK};
        end else if (wb_adr_i == TSM_ADDR_CTRL) begin
          wb_dat_o[TSM_CTRL_RUN_BIT]  <= run_enable;
          wb_dat_o[TSM_CTRL_TRIG_BIT] <= trig_eff;
          wb_dat_o[TSM_CTRL_FILTERED_EXTERNAL_TRIGGER_BIT] <= filtered_external_trigger;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smc <= tsm_smc_type'(TSM_SMC_RESET);
    end else if (wb_req && wb_we_i && wb_adr_i == TSM_ADDR_SMC) begin
      if (wb_sel_i[0]) begin
        smc[7:0] <= wb_dat_i[7:0] & TSM_SMC_WMASK[7:0];
      end
      if (wb_sel_i[1]) begin
        smc[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // Hardware start in trigger mode wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_enable <= TSM_RUN_RESET;
    end else if (smc.mode == TSM_SM_TRIGGER && trig_rise) begin
      run_enable <= 1'h1;
    end else if (wb_req && wb_we_i && wb_adr_i == TSM_ADDR_CTRL && wb_sel_i[0]) begin
      run_enable <= wb_dat_i[TSM_CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_sync1 <= 1'h0;
      ext_sync2 <= 1'h0;
    end else begin
      ext_sync1 <= external_trigger_pin_i;
      ext_sync2 <= ext_sync1;
    end
  end

  assign ext_pol = ext_sync2 ^ smc.polarity;

  // Prescaler counts active edges; counter bits divide by 2, 4, 8
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pol_q  <= 1'h0;
      ps_cnt <= 3'h0;
    end else begin
      pol_q <= ext_pol;
      if (ext_pol && !pol_q) begin
        ps_cnt <= ps_cnt + 3'h1;
      end
    end
  end

  always_comb begin
    unique case (smc.prescale)
      TSM_PS_DIV1: prescaled_external_trigger = ext_pol;
      TSM_PS_DIV2: prescaled_external_trigger = ps_cnt[0];
      TSM_PS_DIV4: prescaled_external_trigger = ps_cnt[1];
      default:     prescaled_external_trigger = ps_cnt[2];
    endcase
  end

  // Sampling base clock tick, then sampling divider for the filter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dts_cnt  <= 5'h00;
      samp_cnt <= 5'h00;
    end else begin
      dts_cnt <= dts_tick ? 5'h00 : dts_cnt + 5'h01;
      if (dts_tick) begin
        samp_cnt <= samp_cnt + 5'h01;
      end
    end
  end

  assign dts_tick = (dts_cnt + 5'h01 >= TSM_DTS_DIV);

  always_comb begin
    if (smc.filter != 4'h0 && smc.filter < 4'h4) begin
      samp_en = 1'h1;
    end else begin
      samp_en = dts_tick && ((samp_cnt & tsm_filter_mask(smc.filter))
                             == tsm_filter_mask(smc.filter));
    end
  end

  tsm_filter u_filter (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sample_en_i (samp_en),
    .level_i     (prescaled_external_trigger),
    .len_i       (tsm_filter_len(smc.filter)),
    .level_o     (filtered_external_trigger)
  );

  assign channel1_edge_pulse = channel1_filtered_raw_i ^ ch1_q;

  // Trigger source mux; channel inputs arrive polarity-adjusted
  always_comb begin
    unique case (smc.source)
      TSM_TS_CH1_EDGE: trigger_input_signal = channel1_edge_pulse;
      TSM_TS_CH1:      trigger_input_signal = filtered_channel1_input_i;
      TSM_TS_CH2:      trigger_input_signal = filtered_channel2_input_i;
      TSM_TS_FILTERED_EXTERNAL_TRIGGER:     trigger_input_signal = filtered_external_trigger;
      default:         trigger_input_signal = internal_trigger_i[smc.source[1:0]];
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch1_q      <= 1'h0;
      filtered_external_trigger_q     <= 1'h0;
      trig_delay <= 1'h0;
      trig_q     <= 1'h0;
    end else begin
      ch1_q      <= channel1_filtered_raw_i;
      filtered_external_trigger_q     <= filtered_external_trigger;
      trig_delay <= trigger_input_signal;
      trig_q     <= trig_eff;
    end
  end

  // Extra stage gives a master time to drive its slaves in step
  assign trig_eff  = smc.sync ? trig_delay : trigger_input_signal;
  assign trig_rise = trig_eff && !trig_q;
  assign filtered_external_trigger_rise = filtered_external_trigger && !filtered_external_trigger_q;

  always_comb begin
    next_tick = run_enable;
    if (smc.clock_mode2) begin
      next_tick = run_enable && filtered_external_trigger_rise;
    end else if (smc.mode == TSM_SM_EXTCLK) begin
      next_tick = run_enable && trig_rise;
    end
    if (smc.mode == TSM_SM_GATED && !trig_eff) begin
      next_tick = 1'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_o <= '0;
    end else begin
      ctl_o.run_enable <= run_enable;
      ctl_o.count_tick <= next_tick;
      ctl_o.reinit     <= (smc.mode == TSM_SM_RESET) && trig_rise;
      ctl_o.trig_level <= trig_eff;
      ctl_o.trig_rise  <= trig_rise;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_pin_sync_two: assert property (
    (ext_pol == ($past(external_trigger_pin_i, 2) ^ smc.polarity)) || $changed(smc.polarity))
    else $error("trigger pin not seen two cycles later");
  a_polarity_invert: assert property (
    smc.polarity |-> ext_pol != ext_sync2)
    else $error("polarity inversion wrong");
  a_prescale_div2: assert property (
    smc.prescale == TSM_PS_DIV2 && ext_pol && !pol_q ##1 smc.prescale == TSM_PS_DIV2
    |-> prescaled_external_trigger != $past(prescaled_external_trigger))
    else $error("divide by two did not toggle on edge");
  a_clock_mode2_tick: assert property (
    smc.clock_mode2 && smc.mode != TSM_SM_GATED && run_enable && filtered_external_trigger_rise
    |=> ctl_o.count_tick)
    else $error("clock mode 2 edge lost");
  a_clock_mode2_only: assert property (
    smc.clock_mode2 && !filtered_external_trigger_rise |=> !ctl_o.count_tick)
    else $error("tick without external edge in mode 2");
  a_reset_mode: assert property (
    smc.mode == TSM_SM_RESET && trig_rise |=> ctl_o.reinit)
    else $error("reset mode missed reinit");
  a_gated_hold: assert property (
    smc.mode == TSM_SM_GATED && !trig_eff |=> !ctl_o.count_tick && !ctl_o.reinit)
    else $error("gated mode counted while low");
  a_trigger_start: assert property (
    smc.mode == TSM_SM_TRIGGER && trig_rise |=> run_enable ##1 ctl_o.run_enable)
    else $error("trigger mode did not start counter");
  a_extclk_edge: assert property (
    !smc.clock_mode2 && smc.mode == TSM_SM_EXTCLK && !trig_rise |=> !ctl_o.count_tick)
    else $error("mode 1 tick without rising edge");
  a_sync_delay: assert property (
    smc.sync && $stable(smc) && $rose(trigger_input_signal) |=> trig_eff)
    else $error("sync delay stage wrong");
  a_edge_pulse: assert property (
    $changed(channel1_filtered_raw_i) |-> channel1_edge_pulse)
    else $error("channel 1 transition without pulse");
  a_free_run: assert property (
    smc.mode == TSM_SM_OFF && !smc.clock_mode2 && run_enable |=> ctl_o.count_tick)
    else $error("disabled slave mode did not run");
  a_prescale_div4: assert property (
    smc.prescale == TSM_PS_DIV4 && $stable(smc.prescale) && $changed(prescaled_external_trigger)
    |-> $past(ext_pol) && !$past(pol_q))
    else $error("divide by four moved without an active edge");
  a_filter_hold: assert property (
    !samp_en |=> $stable(filtered_external_trigger))
    else $error("filter output moved without a sample");
  a_reinit_only_reset: assert property (
    smc.mode != TSM_SM_RESET |=> !ctl_o.reinit)
    else $error("reinit outside reset mode");
  a_run_hold: assert property (
    !(smc.mode == TSM_SM_TRIGGER && trig_rise)
    && !(wb_req && wb_we_i && wb_adr_i == TSM_ADDR_CTRL) |=> $stable(run_enable))
    else $error("run enable changed without cause");
  a_sync_off_direct: assert property (
    !smc.sync |-> trig_eff == trigger_input_signal)
    else $error("trigger delayed while sync is off");

  c_reset_mode: cover property (smc.mode == TSM_SM_RESET ##1 ctl_o.reinit);
  c_trigger_start: cover property (smc.mode == TSM_SM_TRIGGER && $rose(run_enable));
  c_mode2_tick: cover property (smc.clock_mode2 && filtered_external_trigger_rise ##1 ctl_o.count_tick);
  c_filter_long: cover property (smc.filter == 4'hf && $rose(filtered_external_trigger));

endmodule

//--- tsm_etr_model.sv
`timescale 1ns/1ps
module tsm_etr_model (
  input  wire logic clk_i,
  output logic      pin_o
);
  initial pin_o = 1'b0;
  task automatic hold(input logic lv);
    @(posedge clk_i);
    pin_o <= lv;
  endtask
  // Pulse train away from idle level lv; never faster than a quarter of the clock
  task automatic burst(input int w, input int k, input logic lv);
    int hw;
    hw = (w < 2) ? 2 : w;
    repeat (k) begin
      @(posedge clk_i);
      pin_o <= ~lv;
      repeat (hw) @(posedge clk_i);
      pin_o <= lv;
      repeat (hw - 1) @(posedge clk_i);
    end
  endtask
endmodule

//--- tsm_slave_mode_tb.sv
`timescale 1ns/1ps
module tsm_slave_mode_tb;
  import tsm_pkg::*;
  typedef struct {logic rd; logic [31:0] v;} tsm_note_type;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]   adr = 8'h00;
  logic [3:0]   sel = 4'h0;
  logic [31:0]  dat_w = 32'h0, dat_r, v;
  logic         ack, etr;
  logic [3:0]   itrig = 4'h0;
  logic         ch1_raw = 1'b0, ch1_f = 1'b0, ch2_f = 1'b0;
  tsm_ctl_type  ctl;
  tsm_note_type notes[$], nt;
  int           fails = 0, n_tests = 0, ticks = 0, reinits = 0;
  int           fc[4] = '{1, 3, 3, 4}, fw[4] = '{4, 4, 12, 16}, fe[4] = '{4, 0, 4, 4};

  always #2.5 clk_i = ~clk_i;

  tsm_etr_model i_tsm_etr_model (.clk_i(clk_i), .pin_o(etr));
  tsm_slave_mode i_tsm_slave_mode (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .external_trigger_pin_i(etr),
    .internal_trigger_i(itrig), .channel1_filtered_raw_i(ch1_raw),
    .filtered_channel1_input_i(ch1_f), .filtered_channel2_input_i(ch2_f), .ctl_o(ctl));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      tally_and_finish();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    notes.push_back('{1'b0, 32'h0});
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{1'b1, e});
    wb(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] smc(input logic p, input logic m2, input logic [1:0] ps,
                                      input logic [3:0] f, input logic [2:0] s,
                                      input logic [2:0] md);
    return {16'h0, p, m2, ps, f, 1'b0, s, 1'b0, md};
  endfunction

  task automatic do_reset;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic clr;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    ticks = 0;
    reinits = 0;
  endtask

  task automatic drive_src(input int s, input logic lv);
    @(posedge clk_i);
    if (s < 4) itrig[s] <= lv;
    else if (s == 4) ch1_raw <= lv;
    else if (s == 5) ch1_f <= lv;
    else ch2_f <= lv;
    repeat (4) @(posedge clk_i);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Scoreboard: every ack retires the oldest note
  always @(posedge clk_i) begin
    if (ack === 1'b1) begin
      if (notes.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        nt = notes.pop_front();
        if (nt.rd) check(dat_r, nt.v);
      end
    end
    if (ctl.count_tick === 1'b1) ticks++;
    if (ctl.reinit === 1'b1) reinits++;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    tally_and_finish();
  end

  initial begin
    v = $urandom(32'hc23b);
    do_reset();
    rd(TSM_ADDR_SMC, 32'h0);
    rd(8'h40, 32'h0);
    v = $urandom;
    wr(TSM_ADDR_SMC, v);
    rd(TSM_ADDR_SMC, {16'h0, v[15:0] & TSM_SMC_WMASK});
    wr(TSM_ADDR_SMC, 32'h0);
    wr(TSM_ADDR_CTRL, 32'h0);
    i_tsm_etr_model.hold(1'b1);
    settle(8);
    rd(TSM_ADDR_CTRL, 32'h4);
    wr(TSM_ADDR_SMC, smc(1, 0, 0, 0, 0, 0));
    settle(8);
    rd(TSM_ADDR_CTRL, 32'h0);
    i_tsm_etr_model.hold(1'b0);
    wr(TSM_ADDR_SMC, 32'h0);
    wr(TSM_ADDR_CTRL, 32'h1);
    for (int md = 0; md < 4; md++) begin
      wr(TSM_ADDR_SMC, smc(0, 0, 0, 0, 0, md[2:0]));
      clr();
      settle(10);
      check(ticks, 10);
    end
    wr(TSM_ADDR_SMC, smc(0, 0, 0, 0, 2, 0));
    wr(TSM_ADDR_SMC, smc(0, 0, 0, 0, 2, 5));
    clr();
    @(posedge clk_i);
    itrig[2] <= 1'b1;
    repeat (20) @(posedge clk_i);
    itrig[2] <= 1'b0;
    settle(8);
    check(ticks, 20);
    check(reinits, 0);
    wr(TSM_ADDR_CTRL, 32'h0);
    for (int s = 0; s < 7; s++) begin
      wr(TSM_ADDR_SMC, smc(0, 0, 0, 0, s[2:0], 0));
      wr(TSM_ADDR_SMC, smc(0, 0, 0, 0, s[2:0], 4) | ((s == 1) ? 32'h80 : 32'h0));
      clr();
      repeat (2) begin
        drive_src(s, 1'b1);
        drive_src(s, 1'b0);
      end
      settle(6);
      check(reinits, (s == 4) ? 4 : 2);
    end
    wr(TSM_ADDR_SMC, smc(0, 0, 0, 0, 0, 0));
    wr(TSM_ADDR_SMC, smc(0, 0, 0, 0, 0, 6));
    clr();
    drive_src(0, 1'b1);
    drive_src(0, 1'b0);
    settle(4);
    check(ctl.run_enable, 1'b1);
    check(reinits, 0);
    rd(TSM_ADDR_CTRL, 32'h1);
    for (int i = 0; i < 12; i++) begin
      do_reset();
      wr(TSM_ADDR_CTRL, 32'h1);
      wr(TSM_ADDR_SMC, smc(0, i / 4 > 0, i[1:0], 0, (i / 4 == 1) ? 0 : 7, 0));
      if (i / 4 != 1) wr(TSM_ADDR_SMC, smc(0, i / 4 == 2, i[1:0], 0, 7, 7));
      clr();
      i_tsm_etr_model.burst(2, 16, 1'b0);
      settle(12);
      check(ticks, 16 >> i[1:0]);
    end
    for (int k = 0; k < 4; k++) begin
      do_reset();
      wr(TSM_ADDR_CTRL, 32'h1);
      wr(TSM_ADDR_SMC, smc(0, 0, 0, fc[k], 7, 0));
      wr(TSM_ADDR_SMC, smc(0, 0, 0, fc[k], 7, 7));
      clr();
      i_tsm_etr_model.burst(fw[k], 4, 1'b0);
      settle(20);
      check(ticks, fe[k]);
    end
    tally_and_finish();
  end
endmodule
